// *** design/isr_routing.sv ***
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "isr_defines.svh"
module isr_routing
    import isr_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Avalon-MM register slave.
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt sources.
    input wire logic [`ISR_NPIN-1:0] external_irq_pins,
    input wire logic [`ISR_NKEY-1:0] key_wake_inputs,
    input wire logic dma_done_irq,
    input wire logic [`ISR_NPER-1:0] periph_irq,
    // Request to the core.
    output logic cpu_irq_req,
    output logic [2:0] cpu_irq_level,
    output logic [9:0] cpu_irq_vector,
    // DMA trigger, stop wake-up and block interrupt.
    output logic dma_trigger,
    output logic stop_wakeup,
    output logic irq
);
    // Bus handshake and read data.
    logic wait_ff;
    logic [31:0] rdata_ff;
    // Controller source mode: priority and polarity.
    logic [`ISR_NSRC-1:0][2:0] prio_ff;
    logic [`ISR_NSRC-1:0][1:0] pol_ff;
    // Clock generator wake control; the last entry serves the key group.
    logic [`ISR_NWAKE-1:0][1:0] wsense_ff;
    logic [`ISR_NWAKE-1:0] wen_ff;
    logic [`ISR_NWAKE-1:0] wake_req_ff;
    // Key block status: per-key sense and enable.
    logic [`ISR_NKEY-1:0][1:0] ksense_ff;
    logic [`ISR_NKEY-1:0] ken_ff;
    // Pending requests and their interrupt mask.
    logic [`ISR_NSRC-1:0] pending_ff;
    logic [`ISR_NSRC-1:0] irq_mask_ff;
    // Core status word copy.
    logic [2:0] core_mask_ff;
    logic core_en_ff;
    // DMA trigger source selection.
    logic [3:0] dma_sel_ff;
    logic dma_en_ff;
    // Registered outputs.
    logic cpu_req_ff;
    logic [2:0] cpu_lvl_ff;
    logic [9:0] cpu_vec_ff;
    logic dma_trig_ff;
    logic wake_out_ff;
    logic irq_ff;
    // Combinational helpers.
    logic wr_go;
    logic [5:0] rgn;
    logic [3:0] idx;
    logic [31:0] rd_word;
    logic [31:0] wval;
    logic [31:0] wbits;
    logic [`ISR_NPIN-1:0] pin_hit;
    logic [`ISR_NKEY-1:0] key_hit;
    logic dma_hit;
    logic [`ISR_NPER-1:0] per_hit;
    logic key_any;
    logic [`ISR_NSRC-1:0] src_hit;
    logic [`ISR_NSRC-1:0] clr_vec;
    logic [`ISR_NWAKE-1:0] wclr_vec;
    isr_pick_type pick;

    // Merges write data into a word under the byte enables.
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Finds the highest non-zero level; the lower source number wins a tie.
    function automatic isr_pick_type pick_best(input logic [`ISR_NSRC-1:0] pend,
                                               input logic [`ISR_NSRC-1:0][2:0] lv);
        isr_pick_type r;
        r = '0;
        for (int i = `ISR_NSRC - 1; i >= 0; i--) begin
            if (pend[i] && (lv[i] != `ISR_PRIO_OFF) && (lv[i] >= r.lvl)) begin
                r.found = 1'b1;
                r.idx = 4'(i);
                r.lvl = lv[i];
            end
        end
        return r;
    endfunction

    // Vector of a source: its number in bits 7:4.
    function automatic logic [9:0] vec_of(input logic [3:0] n);
        return {2'h0, n, 4'h0};
    endfunction

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign cpu_irq_req = cpu_req_ff;
    assign cpu_irq_level = cpu_lvl_ff;
    assign cpu_irq_vector = cpu_vec_ff;
    assign dma_trigger = dma_trig_ff;
    assign stop_wakeup = wake_out_ff;
    assign irq = irq_ff;

    // Address decode and write values.
    assign rgn = avs_address[`ISR_ADDR_RGN];
    assign idx = avs_address[`ISR_ADDR_IDX];
    assign wr_go = avs_write && !wait_ff;
    assign wval = be_merge(rd_word, avs_writedata, avs_byteenable);
    assign wbits = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    assign pick = pick_best(pending_ff, prio_ff);

    // Pins: wake-routed pins use the wake sense, others the controller polarity.
    genvar p;
    generate
        for (p = 0; p < `ISR_NPIN; p++) begin : g_pin
            isr_sense_unit #(.SYNC_EN(1'b1)) u_pin (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .raw(external_irq_pins[p]),
                .mode(isr_sense_type'(wen_ff[p] ? wsense_ff[p] : pol_ff[`ISR_SRC_PIN0 + p])),
                .hit(pin_hit[p])
            );
        end
        // Keys always take sense from their own status entry.
        for (p = 0; p < `ISR_NKEY; p++) begin : g_key
            isr_sense_unit #(.SYNC_EN(1'b1)) u_key (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .raw(key_wake_inputs[p]),
                .mode(isr_sense_type'(ksense_ff[p])),
                .hit(key_hit[p])
            );
        end
        // On-chip peripherals share this clock and detect a rising edge.
        for (p = 0; p < `ISR_NPER; p++) begin : g_per
            isr_sense_unit #(.SYNC_EN(1'b0)) u_per (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .raw(periph_irq[p]),
                .mode(ISR_RISE),
                .hit(per_hit[p])
            );
        end
    endgenerate

    // DMA completion is detected on its falling edge.
    isr_sense_unit #(.SYNC_EN(1'b0)) u_dma (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .raw(dma_done_irq),
        .mode(ISR_FALL),
        .hit(dma_hit)
    );

    // Source events; a wake-routed source is seen as the wake latch level.
    always_comb begin
        key_any = |(key_hit & ken_ff);
        src_hit = '0;
        src_hit[`ISR_SRC_SW] = 1'b1;
        for (int i = 0; i < `ISR_NPIN; i++) begin
            src_hit[`ISR_SRC_PIN0 + i] = wen_ff[i] ? wake_req_ff[i] : pin_hit[i];
        end
        src_hit[`ISR_SRC_KEY] = wen_ff[`ISR_WAKE_KEY] ? wake_req_ff[`ISR_WAKE_KEY] : key_any;
        src_hit[`ISR_SRC_DMA] = dma_hit;
        src_hit[`ISR_SRC_PER0 +: `ISR_NPER] = per_hit;
    end

    // Clear vectors from the code registers and the status register.
    always_comb begin
        clr_vec = '0;
        wclr_vec = '0;
        if (wr_go && (avs_address == `ISR_OFF_CLR) && (wbits[`ISR_CLR_CODE] < `ISR_CODE_LIM)) begin
            clr_vec[wbits[`ISR_CODE_IDX]] = 1'b1;
        end
        if (wr_go && (avs_address == `ISR_OFF_STAT)) begin
            clr_vec = clr_vec | wbits[`ISR_STAT_BITS];
        end
        if (wr_go && (avs_address == `ISR_OFF_WCLR) && (wbits[`ISR_WCLR_CODE] < `ISR_WAKE_LIM)) begin
            wclr_vec[wbits[`ISR_WCLR_CODE]] = 1'b1;
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_word = '0;
        if (rgn == `ISR_RGN_MODE) begin
            rd_word[`ISR_PRIO] = prio_ff[idx];
            rd_word[`ISR_POL] = pol_ff[idx];
        end else if ((rgn == `ISR_RGN_WAKE) && (idx < `ISR_WAKE_LIM)) begin
            rd_word[`ISR_WSENSE] = wsense_ff[idx];
            rd_word[`ISR_WEN] = wen_ff[idx];
        end else if ((rgn == `ISR_RGN_KEY) && (idx < `ISR_KEY_LIM)) begin
            rd_word[`ISR_KSENSE] = ksense_ff[idx];
            rd_word[`ISR_KEN] = ken_ff[idx];
        end else if (rgn == `ISR_RGN_FIX) begin
            unique case (avs_address)
                `ISR_OFF_CORE: begin
                    rd_word[`ISR_CORE_MASK] = core_mask_ff;
                    rd_word[`ISR_CORE_EN] = core_en_ff;
                end
                `ISR_OFF_STAT: rd_word[`ISR_STAT_BITS] = pending_ff;
                `ISR_OFF_MASK: rd_word[`ISR_STAT_BITS] = irq_mask_ff;
                `ISR_OFF_PICK: begin
                    rd_word[`ISR_PICK_VEC] = vec_of(pick.idx);
                    rd_word[`ISR_PICK_LVL] = pick.lvl;
                    rd_word[`ISR_PICK_FOUND] = pick.found;
                end
                `ISR_OFF_DMA: begin
                    rd_word[`ISR_DMA_SEL] = dma_sel_ff;
                    rd_word[`ISR_DMA_EN] = dma_en_ff;
                end
                default: rd_word = '0;
            endcase
        end
    end

    // Waitrequest drops for one cycle per request; read data is captured then.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            wait_ff <= !((avs_read || avs_write) && wait_ff);
            if (avs_read && wait_ff) begin
                rdata_ff <= rd_word;
            end
        end
    end

    // Source mode registers: priority and controller polarity.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_ff <= '0;
            pol_ff <= {`ISR_NSRC{`ISR_RST_POL}};
        end else if (ce && wr_go && (rgn == `ISR_RGN_MODE)) begin
            prio_ff[idx] <= wval[`ISR_PRIO];
            pol_ff[idx] <= wval[`ISR_POL];
        end
    end

    // Wake control registers in the clock generator part.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wsense_ff <= {`ISR_NWAKE{`ISR_RST_SENSE}};
            wen_ff <= '0;
        end else if (ce && wr_go && (rgn == `ISR_RGN_WAKE) && (idx < `ISR_WAKE_LIM)) begin
            wsense_ff[idx] <= wval[`ISR_WSENSE];
            wen_ff[idx] <= wval[`ISR_WEN];
        end
    end

    // Key status registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ksense_ff <= {`ISR_NKEY{`ISR_RST_SENSE}};
            ken_ff <= '0;
        end else if (ce && wr_go && (rgn == `ISR_RGN_KEY) && (idx < `ISR_KEY_LIM)) begin
            ksense_ff[idx] <= wval[`ISR_KSENSE];
            ken_ff[idx] <= wval[`ISR_KEN];
        end
    end

    // Core status word, interrupt mask and DMA selection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_mask_ff <= 3'h0;
            core_en_ff <= 1'b0;
            irq_mask_ff <= '0;
            dma_sel_ff <= 4'h0;
            dma_en_ff <= 1'b0;
        end else if (ce && wr_go) begin
            if (avs_address == `ISR_OFF_CORE) begin
                core_mask_ff <= wval[`ISR_CORE_MASK];
                core_en_ff <= wval[`ISR_CORE_EN];
            end
            if (avs_address == `ISR_OFF_MASK) begin
                irq_mask_ff <= wval[`ISR_STAT_BITS];
            end
            if (avs_address == `ISR_OFF_DMA) begin
                dma_sel_ff <= wval[`ISR_DMA_SEL];
                dma_en_ff <= wval[`ISR_DMA_EN];
            end
        end
    end

    // Pending and wake latches; a new event wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_ff <= '0;
            wake_req_ff <= '0;
        end else if (ce) begin
            pending_ff <= (pending_ff & ~clr_vec) | src_hit;
            wake_req_ff <= (wake_req_ff & ~wclr_vec) | (wen_ff & {key_any, pin_hit});
        end
    end

    // Forward the top request when enabled and above the core mask level.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_req_ff <= 1'b0;
            cpu_lvl_ff <= 3'h0;
            cpu_vec_ff <= 10'h000;
        end else if (ce) begin
            cpu_req_ff <= pick.found && core_en_ff && (pick.lvl > core_mask_ff);
            cpu_lvl_ff <= pick.found ? pick.lvl : `ISR_PRIO_OFF;
            cpu_vec_ff <= pick.found ? vec_of(pick.idx) : 10'h000;
        end
    end

    // DMA trigger pulse, wake-up level and block interrupt.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_trig_ff <= 1'b0;
            wake_out_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (ce) begin
            dma_trig_ff <= dma_en_ff && src_hit[dma_sel_ff] && !pending_ff[dma_sel_ff];
            wake_out_ff <= |wake_req_ff;
            irq_ff <= |(pending_ff & irq_mask_ff);
        end
    end

    // Checking helpers: independent top level and delayed pending.
    logic [2:0] max_lvl;
    logic [`ISR_NSRC-1:0] pend_d_ff;
    always_comb begin
        max_lvl = `ISR_PRIO_OFF;
        for (int i = 0; i < `ISR_NSRC; i++) begin
            if (pending_ff[i] && (prio_ff[i] > max_lvl)) begin
                max_lvl = prio_ff[i];
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_d_ff <= '0;
        end else if (ce) begin
            pend_d_ff <= pending_ff;
        end
    end

    default clocking cb @(posedge clk iff ce); endclocking
    default disable iff (!rst_n);

    property p_zero_blocked;
        cpu_req_ff |-> cpu_lvl_ff != `ISR_PRIO_OFF;
    endproperty
    a_zero_blocked: assert property (p_zero_blocked) else $error("Level zero forwarded.");
    property p_mask_gate;
        cpu_req_ff |-> $past(core_en_ff) && (cpu_lvl_ff > $past(core_mask_ff));
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("Request passed core gate.");
    property p_rank;
        cpu_req_ff |-> cpu_lvl_ff == $past(max_lvl);
    endproperty
    a_rank: assert property (p_rank) else $error("Forwarded level is not top.");
    property p_vector;
        cpu_req_ff |-> (cpu_vec_ff[3:0] == 4'h0) && pend_d_ff[cpu_vec_ff[7:4]];
    endproperty
    a_vector: assert property (p_vector) else $error("Vector names no pending source.");
    property p_dma;
        dma_trig_ff |-> pending_ff[$past(dma_sel_ff)];
    endproperty
    a_dma: assert property (p_dma) else $error("DMA trigger without request.");
    property p_wake_set;
        wen_ff[0] && pin_hit[0] |=> wake_req_ff[0];
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("Wake latch missed event.");
    property p_wake_gate;
        $rose(wake_req_ff[0]) |-> $past(wen_ff[0]);
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("Wake latch set while off.");
    property p_direct;
        !wen_ff[0] && pin_hit[0] |=> pending_ff[`ISR_SRC_PIN0];
    endproperty
    a_direct: assert property (p_direct) else $error("Direct pin event lost.");
    property p_key_gate;
        $rose(wake_req_ff[`ISR_WAKE_KEY]) |-> $past(wen_ff[`ISR_WAKE_KEY]);
    endproperty
    a_key_gate: assert property (p_key_gate) else $error("Key wake set while off.");
    property p_clear;
        clr_vec[`ISR_SRC_PIN0] && !src_hit[`ISR_SRC_PIN0] |=> !pending_ff[`ISR_SRC_PIN0];
    endproperty
    a_clear: assert property (p_clear) else $error("Clear code left request.");

    // Main scenarios.
    c_cpu_req: cover property (cpu_req_ff);
    c_dma: cover property (dma_trig_ff);
    c_wakeup: cover property ($rose(wake_out_ff));
    c_read: cover property (avs_read && wait_ff ##1 !wait_ff);
endmodule

// *** design/isr_sense_unit.sv ***
`timescale 1ns/1ns
module isr_sense_unit
    import isr_pkg::*;
#(
    parameter bit SYNC_EN = 1'b1
)
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Raw input and its sensing mode.
    input wire logic raw,
    input wire isr_sense_type mode,
    // Detection, high while the chosen condition holds.
    output logic hit
);
    // Accepted level and the level one cycle before.
    logic stab_ff;
    logic prev_ff;
    logic nxt_stab;

    generate
        if (SYNC_EN) begin : g_sync
            // Three stages; the first one feeds only the second.
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                end else if (ce) begin
                    s1_ff <= raw;
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                end
            end
            // A change is accepted once stages two and three agree.
            assign nxt_stab = (s2_ff == s3_ff) ? s3_ff : stab_ff;
        end else begin : g_direct
            // Same-clock sources need no synchroniser.
            assign nxt_stab = raw;
        end
    endgenerate

    // Accepted level and its history for edge detection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stab_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else if (ce) begin
            stab_ff <= nxt_stab;
            prev_ff <= stab_ff;
        end
    end

    // Polarity and edge or level detection per source.
    always_comb begin
        unique case (mode)
            ISR_LOW: hit = !stab_ff;
            ISR_HIGH: hit = stab_ff;
            ISR_FALL: hit = prev_ff && !stab_ff;
            ISR_RISE: hit = !prev_ff && stab_ff;
        endcase
    end
endmodule

// *** pkg/isr_defines.svh ***
`ifndef ISR_DEFINES_SVH
`define ISR_DEFINES_SVH
// Source counts and source numbering.
`define ISR_NSRC 16
`define ISR_NPIN 11
`define ISR_NWAKE 12
`define ISR_NKEY 14
`define ISR_NPER 2
`define ISR_SRC_SW 0
`define ISR_SRC_PIN0 1
`define ISR_SRC_KEY 12
`define ISR_SRC_DMA 13
`define ISR_SRC_PER0 14
`define ISR_WAKE_KEY 11
// Limits for index checks.
`define ISR_WAKE_LIM 4'hC
`define ISR_KEY_LIM 4'hE
`define ISR_CODE_LIM 6'h10
// Register byte offsets and regions.
`define ISR_OFF_CORE 12'h000
`define ISR_OFF_CLR 12'h008
`define ISR_OFF_WCLR 12'h00C
`define ISR_OFF_STAT 12'h010
`define ISR_OFF_MASK 12'h014
`define ISR_OFF_PICK 12'h018
`define ISR_OFF_DMA 12'h01C
`define ISR_RGN_FIX 6'h00
`define ISR_RGN_MODE 6'h01
`define ISR_RGN_WAKE 6'h02
`define ISR_RGN_KEY 6'h03
`define ISR_ADDR_RGN 11:6
`define ISR_ADDR_IDX 5:2
// Field positions.
`define ISR_CORE_MASK 15:13
`define ISR_CORE_EN 0
`define ISR_PRIO 2:0
`define ISR_POL 5:4
`define ISR_WSENSE 1:0
`define ISR_WEN 4
`define ISR_KEN 0
`define ISR_KSENSE 2:1
`define ISR_CLR_CODE 5:0
`define ISR_WCLR_CODE 3:0
`define ISR_CODE_IDX 3:0
`define ISR_DMA_SEL 3:0
`define ISR_DMA_EN 8
`define ISR_PICK_VEC 9:0
`define ISR_PICK_LVL 14:12
`define ISR_PICK_FOUND 16
`define ISR_STAT_BITS 15:0
// Reset values and fixed levels.
`define ISR_RST_POL 2'h1
`define ISR_RST_SENSE 2'h1
`define ISR_PRIO_OFF 3'h0
`endif

// *** pkg/isr_pkg.sv ***
package isr_pkg;
    // Sensing modes in field encoding order: 00 low, 01 high, 10 fall, 11 rise.
    typedef enum logic [1:0] {ISR_LOW, ISR_HIGH, ISR_FALL, ISR_RISE} isr_sense_type;
    // Result of the priority search.
    typedef struct packed {
        logic found;
        logic [3:0] idx;
        logic [2:0] lvl;
    } isr_pick_type;
endpackage

// *** sim/interrupt_sense_wakeup_routing_tb.sv ***
`timescale 1ns/1ns
module interrupt_sense_wakeup_routing_tb;
    import isr_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, avs_read = 0, avs_write = 0, dma = 0;
    logic [11:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, exp_q[$];
    logic avs_waitrequest, cpu_irq_req, dma_trigger, stop_wakeup, irq;
    logic [10:0] pins = '0;
    logic [13:0] keys = '0;
    logic [1:0] per = '0;
    logic [2:0] cpu_irq_level, t_lvl;
    logic [9:0] cpu_irq_vector, t_vec;
    int num_errors = 0, checks = 0, seed = 29, p, n;
    isr_routing isr_routing_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .external_irq_pins(pins),
        .key_wake_inputs(keys), .dma_done_irq(dma), .periph_irq(per),
        .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level),
        .cpu_irq_vector(cpu_irq_vector), .dma_trigger(dma_trigger),
        .stop_wakeup(stop_wakeup), .irq(irq));
    isr_cpu_model #(.LAT(3)) isr_cpu_model_inst (.clk(clk), .rst_n(rst_n),
        .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level),
        .cpu_irq_vector(cpu_irq_vector), .taken_vector(t_vec), .taken_level(t_lvl));
    // The clock toggles every 2 ns.
    initial begin
        forever #2 clk = ~clk;
    end
    // Compares one value and counts it.
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One bus transfer, held until waitrequest is seen low.
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k == 50) begin
            num_errors++;
            report_and_stop;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    // A read notes its expected word for the watcher.
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, '0);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    // The watcher compares each answered read with the oldest note.
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            check("readdata", avs_readdata, exp_q.pop_front());
    end
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        p = $unsigned($random(seed)) % 11;
        rd(12'h000, 32'h0000_0000);
        rd(12'h040, 32'h0000_0010);
        rd(12'h100, 32'h0000_0000);
        rd(12'h010, 32'h0000_0001);
        rd(12'h018, 32'h0000_0000);
        $display("test reset done");
        wr(12'h040, 32'h0000_0003);
        wr(12'h000, 32'h0000_0001);
        wt(4);
        check("req", cpu_irq_req, 1);
        rd(12'h018, 32'h0001_3000);
        wr(12'h000, 32'h0000_6001);
        wt(4);
        check("req masked", cpu_irq_req, 0);
        wr(12'h000, 32'h0000_4001);
        wr(12'h040 + 12'(4 * (p + 1)), 32'h0000_0035);
        pins[p] <= 1'b1;
        wt(12);
        rd(12'h010, (32'h1 << (p + 1)) | 32'h1);
        check("vector", cpu_irq_vector, 10'((p + 1) << 4));
        check("taken", t_lvl, 5);
        check("taken vec", t_vec, 10'((p + 1) << 4));
        check("level", cpu_irq_level, 5);
        wr(12'h008, 32'(p + 1));
        rd(12'h010, 32'h0000_0001);
        wr(12'h014, 32'h1 << (p + 1));
        wr(12'h040 + 12'(4 * (p + 1)), 32'h0000_0025);
        pins[p] <= 1'b0;
        wt(12);
        check("irq", irq, 1);
        wr(12'h010, 32'h1 << (p + 1));
        wt(3);
        check("irq w1c", irq, 0);
        $display("test pin done");
        wr(12'h080 + 12'(4 * p), 32'h0000_0002);
        wr(12'h00C, 32'(p));
        wr(12'h080 + 12'(4 * p), 32'h0000_0012);
        wr(12'h040 + 12'(4 * (p + 1)), 32'h0000_0010);
        wr(12'h008, 32'(p + 1));
        wr(12'h040 + 12'(4 * (p + 1)), 32'h0000_0015);
        wr(12'h000, 32'h0000_4001);
        pins[p] <= 1'b1;
        wt(12);
        check("no wake", stop_wakeup, 0);
        pins[p] <= 1'b0;
        wt(12);
        check("wake", stop_wakeup, 1);
        wr(12'h000, 32'h0000_0000);
        wr(12'h040 + 12'(4 * (p + 1)), 32'h0000_0010);
        wt(4);
        check("req off", cpu_irq_req, 0);
        wr(12'h00C, 32'(p));
        wr(12'h008, 32'(p + 1));
        wr(12'h080 + 12'(4 * p), 32'h0000_0002);
        wt(4);
        check("wake off", stop_wakeup, 0);
        rd(12'h010, 32'h0000_0001);
        // A low-level source requests while its pin is low, and a clear holds once it is high.
        wr(12'h040 + 12'(4 * (p + 1)), 32'h0000_0005);
        wt(2);
        rd(12'h010, (32'h1 << (p + 1)) | 32'h1);
        pins[p] <= 1'b1;
        wt(12);
        wr(12'h008, 32'(p + 1));
        rd(12'h010, 32'h0000_0001);
        $display("test wake done");
        wr(12'h0C0 + 12'(4 * p), 32'h0000_0007);
        wr(12'h0AC, 32'h0000_0011);
        wr(12'h070, 32'h0000_0011);
        keys[p] <= 1'b1;
        wt(12);
        check("key wake", stop_wakeup, 1);
        wr(12'h00C, 32'h0000_000B);
        wr(12'h008, 32'h0000_000C);
        rd(12'h010, 32'h0000_0001);
        $display("test key done");
        wr(12'h01C, 32'h0000_010D);
        wr(12'h014, 32'h0000_2000);
        dma <= 1'b1;
        wt(2);
        dma <= 1'b0;
        n = 0;
        while (dma_trigger !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("dma trigger", dma_trigger, 1);
        if (n == 20) report_and_stop;
        wt(2);
        check("irq dma", irq, 1);
        wr(12'h010, 32'h0000_2000);
        per <= 2'b01;
        wt(1);
        per <= 2'b00;
        wt(4);
        rd(12'h010, 32'h0000_4001);
        check("irq clear", irq, 0);
        // A pulse that comes and goes while the clock enable is low must leave no trace.
        ce <= 1'b0;
        per <= 2'b10;
        wt(3);
        per <= 2'b00;
        wt(1);
        ce <= 1'b1;
        wt(2);
        rd(12'h010, 32'h0000_4001);
        $display("test dma done");
        report_and_stop;
    end
    // A hang is cut short here.
    initial begin
        #200000;
        num_errors++;
        report_and_stop;
    end
endmodule

// *** sim/isr_cpu_model.sv ***
`timescale 1ns/1ns
module isr_cpu_model
    import isr_pkg::*;
#(
    parameter int LAT = 3
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Request offered by the controller.
    input wire logic cpu_irq_req,
    input wire logic [2:0] cpu_irq_level,
    input wire logic [9:0] cpu_irq_vector,
    // What the core last took.
    output logic [9:0] taken_vector,
    output logic [2:0] taken_level
);
    // Cycles the request has stood; a larger LAT models a busy core.
    int hold_ff;
    // The core takes a request only after it has stood LAT cycles.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= 0;
            taken_vector <= '0;
            taken_level <= '0;
        end else if (!cpu_irq_req) begin
            hold_ff <= 0;
        end else if (hold_ff == LAT) begin
            taken_vector <= cpu_irq_vector;
            taken_level <= cpu_irq_level;
        end else begin
            hold_ff <= hold_ff + 1;
        end
    end
endmodule
